// File: hw/afescr_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the slot config bank
// Assumes: 16-bit registers on an 8-bit register address, 250 MHz system clock
// Notes: Definitions only
// Overview of operation
// - Four slot B order bits set per-pulse polarity; 1 reverses; repeats every four.
// - Slot B window width is bits 15:11, 1 us steps, resets to 4.
// - Slot B window offset is bits 10:0, 31.25 ns steps, resets to 0x17.
// - Slot A individual gain: channel 1 local, channels 2-4 from 0x55 bits 5:0.
// - Slot A gain code 0-3 is 200k/100k/50k/25k; all channels unless individual.
// - Slot A reference select 0-3 is 1.14/1.01/0.90/1.27 V; resets to 3.
// - Slot A integrator-as-buffer bit turns integrator into buffer; direct mode only (bit 7 reaches integrator_buffer_select in every path mode).
// - Slot A path word: ADA5 full path (reset), AE65/B065 direct, others reserved.
// - Slot B individual gain: channel 1 from 0x44 bits 1:0, others 0x55 bits 11:6.
`ifndef AFESCR_DEFS_SVH
`define AFESCR_DEFS_SVH

`define AFESCR_ADDR_W 8
`define AFESCR_DATA_W 16

`define AFESCR_OFF_B_ORDER 8'h1D
`define AFESCR_OFF_B_WINDOW 8'h3B
`define AFESCR_OFF_A_GAIN 8'h42
`define AFESCR_OFF_A_PATH 8'h43
`define AFESCR_OFF_B_GAIN 8'h44

`define AFESCR_RST_B_ORDER 16'h0000
`define AFESCR_RST_B_WINDOW 16'h2017
`define AFESCR_RST_A_GAIN 16'h1C38
`define AFESCR_RST_A_PATH 16'hADA5
`define AFESCR_RST_B_GAIN 16'h1C38

`define AFESCR_PATH_FULL 16'hADA5
`define AFESCR_PATH_DIRECT_BUF 16'hAE65
`define AFESCR_PATH_DIRECT_PLAIN 16'hB065

`define AFESCR_ORDER_MSB 3
`define AFESCR_WIDTH_MSB 15
`define AFESCR_WIDTH_LSB 11
`define AFESCR_OFFSET_MSB 10
`define AFESCR_MODE_MSB 15
`define AFESCR_MODE_LSB 10
`define AFESCR_INT_GAIN_MSB 9
`define AFESCR_INT_GAIN_LSB 8
`define AFESCR_AS_BUF_BIT 7
`define AFESCR_IND_EN_BIT 6
`define AFESCR_VREF_MSB 5
`define AFESCR_VREF_LSB 4
`define AFESCR_GAIN_MSB 1
`define AFESCR_A_EXT_LSB 0
`define AFESCR_B_EXT_LSB 6

`define AFESCR_CLK_PERIOD_PS 4000
`define AFESCR_WIDTH_STEP_PS 1000000
`define AFESCR_OFFSET_STEP_PS 31250
`define AFESCR_WIDTH_STEP_CYC (`AFESCR_WIDTH_STEP_PS / `AFESCR_CLK_PERIOD_PS)

`endif

// File: hw/afescr_pkg.sv
// Purpose: Types for the slot config bank
// Assumes: Constants come from afescr_defs.svh
// Notes: Structs carry decoded settings to the analog path
package afescr_pkg;

  typedef enum logic [1:0] {
    AFESCR_PATH_FULL_ANALOG,
    AFESCR_PATH_DIRECT_BUFFERED,
    AFESCR_PATH_DIRECT_PLAIN,
    AFESCR_PATH_RESERVED
  } afescr_path_mode_t;

  typedef struct packed {
    logic [7:0] channel_gain_codes;
    logic [1:0] amplifier_reference_select;
    logic integrator_buffer_select;
    logic [1:0] integrator_gain;
    logic per_channel_gain_enable;
  } afescr_slot_cfg_t;

  typedef struct packed {
    logic [4:0] window_width;
    logic [10:0] window_start_offset;
    logic [15:0] window_width_cycles;
    logic [5:0] front_end_mode_field;
  } afescr_window_t;

endpackage

// File: hw/afescr_top.sv
// Purpose: Slot A and slot B front-end configuration registers with decoded outputs
// Assumes: Register port is the internal side of the serial host port, same clock
// Notes: Per-channel gain word (0x55) lives in another bank and arrives as an input
`include "afescr_defs.svh"

module afescr_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`AFESCR_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [`AFESCR_DATA_W-1:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [`AFESCR_DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic [11:0] per_channel_gain_word,
  input wire logic slot_b_sequence_start,
  input wire logic slot_b_pulse_done,
  output logic slot_b_pulse_reversed,
  output logic [3:0] slot_b_pulse_polarity_pattern,
  output afescr_pkg::afescr_window_t slot_b_window,
  output afescr_pkg::afescr_slot_cfg_t slot_a_cfg,
  output afescr_pkg::afescr_slot_cfg_t slot_b_cfg,
  output logic [15:0] slot_a_path_connection_word,
  output afescr_pkg::afescr_path_mode_t slot_a_path_mode
);

  logic [15:0] slot_b_integration_order_reg;
  logic [15:0] slot_b_integration_window_reg;
  logic [15:0] slot_a_amplifier_gain_control_reg;
  logic [15:0] slot_a_path_connection_reg;
  logic [15:0] slot_b_amplifier_gain_control_reg;
  logic [1:0] pulse_index_reg;
  logic [15:0] rdata_next;
  logic hit;

  // Full words are stored, reserved bits included, so reads return what was written
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slot_b_integration_order_reg <= `AFESCR_RST_B_ORDER;
      slot_b_integration_window_reg <= `AFESCR_RST_B_WINDOW;
      slot_a_amplifier_gain_control_reg <= `AFESCR_RST_A_GAIN;
      slot_a_path_connection_reg <= `AFESCR_RST_A_PATH;
      slot_b_amplifier_gain_control_reg <= `AFESCR_RST_B_GAIN;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        `AFESCR_OFF_B_ORDER: slot_b_integration_order_reg <= reg_wdata;
        `AFESCR_OFF_B_WINDOW: slot_b_integration_window_reg <= reg_wdata;
        `AFESCR_OFF_A_GAIN: slot_a_amplifier_gain_control_reg <= reg_wdata;
        `AFESCR_OFF_A_PATH: slot_a_path_connection_reg <= reg_wdata;
        `AFESCR_OFF_B_GAIN: slot_b_amplifier_gain_control_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    hit = 1'b1;
    case (reg_addr)
      `AFESCR_OFF_B_ORDER: rdata_next = slot_b_integration_order_reg;
      `AFESCR_OFF_B_WINDOW: rdata_next = slot_b_integration_window_reg;
      `AFESCR_OFF_A_GAIN: rdata_next = slot_a_amplifier_gain_control_reg;
      `AFESCR_OFF_A_PATH: rdata_next = slot_a_path_connection_reg;
      `AFESCR_OFF_B_GAIN: rdata_next = slot_b_amplifier_gain_control_reg;
      default:
      begin
        rdata_next = 16'h0000;
        hit = 1'b0;
      end
    endcase
  end

  // Unmapped reads answer zero rather than stall the host port
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rdata <= hit ? rdata_next : 16'h0000;
    end
  end

  // Pulse counter wraps after the fourth pulse
  always_ff @(posedge clk)
  begin
    if (srst || slot_b_sequence_start)
      pulse_index_reg <= 2'h0;
    else if (slot_b_pulse_done)
      pulse_index_reg <= pulse_index_reg + 2'h1;
  end

  assign slot_b_pulse_polarity_pattern = slot_b_integration_order_reg[`AFESCR_ORDER_MSB:0];
  assign slot_b_pulse_reversed = slot_b_pulse_polarity_pattern[pulse_index_reg];

  // Window fields; width also given in clock cycles for the timing core
  always_comb
  begin
    slot_b_window.window_width = slot_b_integration_window_reg[`AFESCR_WIDTH_MSB:`AFESCR_WIDTH_LSB];
    slot_b_window.window_start_offset = slot_b_integration_window_reg[`AFESCR_OFFSET_MSB:0];
    // Taken from the register, not the struct, so the block never reads its own output
    slot_b_window.window_width_cycles =
      16'(32'(slot_b_integration_window_reg[`AFESCR_WIDTH_MSB:`AFESCR_WIDTH_LSB]) * `AFESCR_WIDTH_STEP_CYC);
    slot_b_window.front_end_mode_field =
      slot_b_amplifier_gain_control_reg[`AFESCR_MODE_MSB:`AFESCR_MODE_LSB];
  end

  // Channel 1 always follows the local code; others switch source on individual enable
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_gain
      if (ch == 0)
      begin : g_local
        assign slot_a_cfg.channel_gain_codes[1:0] =
          slot_a_amplifier_gain_control_reg[`AFESCR_GAIN_MSB:0];
        assign slot_b_cfg.channel_gain_codes[1:0] =
          slot_b_amplifier_gain_control_reg[`AFESCR_GAIN_MSB:0];
      end
      else
      begin : g_ext
        assign slot_a_cfg.channel_gain_codes[2*ch+1:2*ch] =
          slot_a_cfg.per_channel_gain_enable ? per_channel_gain_word[`AFESCR_A_EXT_LSB+2*ch-1 -: 2]
          : slot_a_amplifier_gain_control_reg[`AFESCR_GAIN_MSB:0];
        assign slot_b_cfg.channel_gain_codes[2*ch+1:2*ch] =
          slot_b_cfg.per_channel_gain_enable ? per_channel_gain_word[`AFESCR_B_EXT_LSB+2*ch-1 -: 2]
          : slot_b_amplifier_gain_control_reg[`AFESCR_GAIN_MSB:0];
      end
    end
  endgenerate

  assign slot_a_cfg.per_channel_gain_enable = slot_a_amplifier_gain_control_reg[`AFESCR_IND_EN_BIT];
  assign slot_a_cfg.amplifier_reference_select =
    slot_a_amplifier_gain_control_reg[`AFESCR_VREF_MSB:`AFESCR_VREF_LSB];
  assign slot_a_cfg.integrator_buffer_select = slot_a_amplifier_gain_control_reg[`AFESCR_AS_BUF_BIT];
  assign slot_a_cfg.integrator_gain =
    slot_a_amplifier_gain_control_reg[`AFESCR_INT_GAIN_MSB:`AFESCR_INT_GAIN_LSB];
  assign slot_b_cfg.per_channel_gain_enable = slot_b_amplifier_gain_control_reg[`AFESCR_IND_EN_BIT];
  assign slot_b_cfg.amplifier_reference_select =
    slot_b_amplifier_gain_control_reg[`AFESCR_VREF_MSB:`AFESCR_VREF_LSB];
  assign slot_b_cfg.integrator_buffer_select = slot_b_amplifier_gain_control_reg[`AFESCR_AS_BUF_BIT];
  assign slot_b_cfg.integrator_gain =
    slot_b_amplifier_gain_control_reg[`AFESCR_INT_GAIN_MSB:`AFESCR_INT_GAIN_LSB];

  assign slot_a_path_connection_word = slot_a_path_connection_reg;

  // Reserved codes are flagged, not corrected; software owns the companion bits
  always_comb
  begin
    case (slot_a_path_connection_reg)
      `AFESCR_PATH_FULL: slot_a_path_mode = afescr_pkg::AFESCR_PATH_FULL_ANALOG;
      `AFESCR_PATH_DIRECT_BUF: slot_a_path_mode = afescr_pkg::AFESCR_PATH_DIRECT_BUFFERED;
      `AFESCR_PATH_DIRECT_PLAIN: slot_a_path_mode = afescr_pkg::AFESCR_PATH_DIRECT_PLAIN;
      default: slot_a_path_mode = afescr_pkg::AFESCR_PATH_RESERVED;
    endcase
  end

endmodule

// File: verification/afescr_chk.sv
// Purpose: Port assertions for the slot config bank
// Assumes: Decoded outputs follow the registers in the same cycle
// Notes: Bound to afescr_top by port name
module afescr_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic [11:0] per_channel_gain_word,
  input wire logic slot_b_sequence_start,
  input wire logic slot_b_pulse_done,
  input wire logic slot_b_pulse_reversed,
  input wire logic [3:0] slot_b_pulse_polarity_pattern,
  input wire afescr_pkg::afescr_window_t slot_b_window,
  input wire afescr_pkg::afescr_slot_cfg_t slot_a_cfg,
  input wire afescr_pkg::afescr_slot_cfg_t slot_b_cfg,
  input wire logic [15:0] slot_a_path_connection_word,
  input wire afescr_pkg::afescr_path_mode_t slot_a_path_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Own pulse count, so pattern checks need no back-to-back strobes
  logic [1:0] seen_dones_reg;
  always_ff @(posedge clk)
  begin
    if (srst || slot_b_sequence_start)
      seen_dones_reg <= 2'h0;
    else if (slot_b_pulse_done)
      seen_dones_reg <= seen_dones_reg + 2'h1;
  end
  a_rd_valid_once: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing one cycle after strobe");
  a_rd_valid_quiet: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid without a strobe");
  a_path_write_lands: assert property (reg_wr_en && reg_addr == 8'h43
    |=> slot_a_path_connection_word == $past(reg_wdata))
    else $error("path word write lost");
  a_path_read_back: assert property (reg_rd_en && !reg_wr_en && reg_addr == 8'h43
    |=> reg_rdata == slot_a_path_connection_word)
    else $error("path word read back wrong");
  a_path_direct_buf: assert property (slot_a_path_connection_word == 16'hAE65
    |-> slot_a_path_mode == afescr_pkg::AFESCR_PATH_DIRECT_BUFFERED)
    else $error("buffered direct path not decoded");
  a_width_in_cycles: assert property (
    slot_b_window.window_width_cycles == slot_b_window.window_width * 16'h00FA)
    else $error("window width cycles wrong");
  a_order_first_pulse: assert property (slot_b_sequence_start
    |=> slot_b_pulse_reversed == slot_b_pulse_polarity_pattern[0])
    else $error("first pulse polarity wrong");
  a_order_follows: assert property (
    slot_b_pulse_reversed == slot_b_pulse_polarity_pattern[seen_dones_reg])
    else $error("pulse polarity does not follow its order bit");
  a_order_wraps: assert property (slot_b_pulse_done && !slot_b_sequence_start && seen_dones_reg == 2'h3
    |=> slot_b_pulse_reversed == slot_b_pulse_polarity_pattern[0])
    else $error("polarity pattern does not repeat after four pulses");
  a_a_shared_gain: assert property (!slot_a_cfg.per_channel_gain_enable
    |-> slot_a_cfg.channel_gain_codes == {4{slot_a_cfg.channel_gain_codes[1:0]}})
    else $error("slot A shared gain not on all channels");
  a_a_individual_gain: assert property (slot_a_cfg.per_channel_gain_enable
    |-> slot_a_cfg.channel_gain_codes[7:2] == per_channel_gain_word[5:0])
    else $error("slot A channel 2 to 4 gain wrong");
  a_b_individual_gain: assert property (slot_b_cfg.per_channel_gain_enable
    |-> slot_b_cfg.channel_gain_codes[7:2] == per_channel_gain_word[11:6])
    else $error("slot B channel 2 to 4 gain wrong");
endmodule

bind afescr_top afescr_chk i_afescr_chk (.*);

// File: verification/afescr_top_tb.sv
// Purpose: Register and decode checks for the slot config bank
// Assumes: Reads answer one cycle after the strobe
// Notes: The 0x55 gain word is driven as a fixed level
module afescr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic reg_rd_valid;
  logic [11:0] per_channel_gain_word = 12'hE4B;
  logic slot_b_sequence_start = 1'b0;
  logic slot_b_pulse_done = 1'b0;
  logic slot_b_pulse_reversed;
  logic [3:0] slot_b_pulse_polarity_pattern;
  afescr_pkg::afescr_window_t slot_b_window;
  afescr_pkg::afescr_slot_cfg_t slot_a_cfg;
  afescr_pkg::afescr_slot_cfg_t slot_b_cfg;
  logic [15:0] slot_a_path_connection_word;
  afescr_pkg::afescr_path_mode_t slot_a_path_mode;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] offs [5] = '{8'h1D, 8'h3B, 8'h42, 8'h43, 8'h44};
  logic [15:0] rsts [5] = '{16'h0000, 16'h2017, 16'h1C38, 16'hADA5, 16'h1C38};
  logic [15:0] paths [4] = '{16'hB065, 16'h1234, 16'hADA5, 16'hAE65};
  logic [1:0] pmodes [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
  afescr_top i_afescr_top (
    .clk(clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .per_channel_gain_word(per_channel_gain_word),
    .slot_b_sequence_start(slot_b_sequence_start),
    .slot_b_pulse_done(slot_b_pulse_done),
    .slot_b_pulse_reversed(slot_b_pulse_reversed),
    .slot_b_pulse_polarity_pattern(slot_b_pulse_polarity_pattern),
    .slot_b_window(slot_b_window),
    .slot_a_cfg(slot_a_cfg),
    .slot_b_cfg(slot_b_cfg),
    .slot_a_path_connection_word(slot_a_path_connection_word),
    .slot_a_path_mode(slot_a_path_mode)
  );
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("rd_valid", {15'h0000, reg_rd_valid}, 16'h0001);
    chk("rdata", reg_rdata, e);
  endtask
  task automatic pulse(input logic s, input logic e);
    @(posedge clk);
    slot_b_sequence_start <= s;
    slot_b_pulse_done <= !s;
    @(posedge clk);
    slot_b_sequence_start <= 1'b0;
    slot_b_pulse_done <= 1'b0;
    #1;
    chk("reversed", {15'h0000, slot_b_pulse_reversed}, {15'h0000, e});
  endtask
  // Bounded run so a stuck read cannot hang the bench
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fail_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i]) rd(offs[i], rsts[i]);
    chk("width", {11'h000, slot_b_window.window_width}, 16'h0004);
    chk("offset", {5'h00, slot_b_window.window_start_offset}, 16'h0017);
    chk("cycles", slot_b_window.window_width_cycles, 16'h03E8);
    wr(8'h50, 16'hFFFF);
    rd(8'h50, 16'h0000);
    foreach (paths[i])
    begin
      // Buffered direct path is written after the integrator-buffer bit is set
      wr(8'h42, (i == 3) ? 16'h1CB4 : 16'h1C34);
      wr(8'h43, paths[i]);
      chk("mode", {14'h0000, slot_a_path_mode}, {14'h0000, pmodes[i]});
    end
    wr(8'h42, 16'h1CF6);
    chk("a_codes", {8'h00, slot_a_cfg.channel_gain_codes}, 16'h002E);
    chk("a_buf", {15'h0000, slot_a_cfg.integrator_buffer_select}, 16'h0001);
    chk("a_vref", {14'h0000, slot_a_cfg.amplifier_reference_select}, 16'h0003);
    wr(8'h42, 16'h1CB6);
    chk("a_codes", {8'h00, slot_a_cfg.channel_gain_codes}, 16'h00AA);
    wr(8'h44, 16'h1C47);
    chk("b_codes", {8'h00, slot_b_cfg.channel_gain_codes}, 16'h00E7);
    chk("b_mode", {10'h000, slot_b_window.front_end_mode_field}, 16'h0007);
    rd(8'h44, 16'h1C47);
    wr(8'h1D, 16'h000A);
    chk("pattern", {12'h000, slot_b_pulse_polarity_pattern}, 16'h000A);
    rd(8'h1D, 16'h000A);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b0);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b0);
    wr(8'h3B, 16'hF801);
    chk("cycles", slot_b_window.window_width_cycles, 16'h1E46);
    chk("offset", {5'h00, slot_b_window.window_start_offset}, 16'h0001);
    rd(8'h3B, 16'hF801);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i]) rd(offs[i], rsts[i]);
    chk("mode", {14'h0000, slot_a_path_mode}, 16'h0000);
    close_out();
  end
endmodule
